// ==== verilog/cluster_ctrl_pkg.sv ====
// constants shared by the logic cluster control generator
package cluster_ctrl_pkg;
  localparam int SLICE_COUNT = 8;
  localparam int HALF_COUNT = SLICE_COUNT / 2;
  localparam int LINE_COUNT = 3;
  localparam int SOURCE_COUNT = 2;
  localparam int ACLR_COUNT = 2;
  localparam int LINE_SEL_W = 2;
  localparam logic [1:0] LINE_NONE = 2'h3;
  localparam logic PRESET_VALUE = 1'h1;
  localparam logic CLEAR_VALUE = 1'h0;
  localparam logic EDGE_RISE = 1'h0;
  localparam logic EDGE_FALL = 1'h1;
endpackage

// ==== verilog/logic_cluster.sv ====
// control generator, slice registers and shared arithmetic chain
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - eight slices all take register controls from one shared generator
// - three clock lines and enables, two aclrs, sclr, aload, sload
// - at most two distinct source clocks; third line copies or inverts one
// - each clock line pairs with its own enable; slice follows both
// - rising and falling edge of one source consume two clock lines
// - enable low gates off its clock line: no edges reach registers
// - preset without inversion loads a one through the async load line
// - arithmetic chain can bypass half the slices, freeing that half
// - alternating columns bypass top half or bottom half
// - chain runs vertically from cluster to cluster through the column
module logic_cluster #(
  parameter bit BOTTOM_BYPASS_COLUMN = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // source clocks from outside
  input wire logic [1:0] source_clock,
  // cluster clock line setup
  input wire logic [2:0] line_source_sel,
  input wire logic [2:0] line_edge_sel,
  input wire logic [2:0] cluster_clock_gate,
  // cluster wide controls
  input wire logic [1:0] async_clear,
  input wire logic async_load,
  input wire logic sync_clear,
  input wire logic sync_load,
  // per slice setup and data
  input wire logic [15:0] slice_line_sel,
  input wire logic [7:0] slice_clear_sel,
  input wire logic [7:0] slice_arith_mode,
  input wire logic [7:0] slice_data,
  input wire logic [7:0] slice_load_data,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  // arithmetic chain
  input wire logic half_bypass,
  input wire logic chain_in,
  output logic chain_out,
  // slice and clock line outputs
  output logic [7:0] slice_q,
  output logic [2:0] cluster_clock_tick
);

  // ************************************************************
  // source clock synchronisers
  // ************************************************************
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic [1:0] rise_ev;
  logic [1:0] fall_ev;
  logic [1:0] settled;

  assign settled = ~(sync2_reg ^ sync3_reg);
  assign level_next = (settled & sync3_reg) | (~settled & level_reg);
  assign rise_ev = level_next & ~level_reg;
  assign fall_ev = ~level_next & level_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      level_reg <= 2'h0;
    end else begin
      sync1_reg <= source_clock;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // ************************************************************
  // cluster clock lines
  // ************************************************************
  logic [2:0] line_edge;
  logic [2:0] line_tick;

  // only two sources exist, so three lines share them
  genvar l;
  generate
    for (l = 0; l < cluster_ctrl_pkg::LINE_COUNT; l++) begin : g_line
      // edge choice per line; both edges take two lines
      assign line_edge[l] = (line_edge_sel[l] == cluster_ctrl_pkg::EDGE_FALL)
        ? fall_ev[line_source_sel[l]] : rise_ev[line_source_sel[l]];
      // enable paired with its own line gates it off
      assign line_tick[l] = line_edge[l] & cluster_clock_gate[l];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cluster_clock_tick <= 3'h0;
    end else begin
      cluster_clock_tick <= line_tick;
    end
  end

  // ************************************************************
  // shared arithmetic chain
  // ************************************************************
  logic [8:0] carry;
  logic [7:0] sum;
  logic [7:0] in_chain;

  function automatic logic slice_in_chain(input int idx, input logic byp);
    logic top;
    top = (idx >= cluster_ctrl_pkg::HALF_COUNT);
    if (!byp) begin
      slice_in_chain = 1'b1;
    end else if (BOTTOM_BYPASS_COLUMN) begin
      slice_in_chain = top;
    end else begin
      slice_in_chain = !top;
    end
  endfunction

  assign carry[0] = chain_in;
  // chain enters from the cluster below and leaves above
  assign chain_out = carry[cluster_ctrl_pkg::SLICE_COUNT];

  genvar s;
  generate
    for (s = 0; s < cluster_ctrl_pkg::SLICE_COUNT; s++) begin : g_chain
      // bypassed half passes the carry straight through
      assign in_chain[s] = slice_in_chain(s, half_bypass);
      assign sum[s] = in_chain[s]
        ? (operand_a[s] ^ operand_b[s] ^ carry[s])
        : (operand_a[s] ^ operand_b[s]);
      assign carry[s+1] = in_chain[s]
        ? ((operand_a[s] & operand_b[s]) | (carry[s] &
          (operand_a[s] ^ operand_b[s])))
        : carry[s];
    end
  endgenerate

  // ************************************************************
  // slice registers
  // ************************************************************
  logic [7:0] q_next;
  logic [7:0] slice_tick;
  logic [7:0] slice_aclr;

  // every slice draws from the one shared control set
  generate
    for (s = 0; s < cluster_ctrl_pkg::SLICE_COUNT; s++) begin : g_slice
      logic [1:0] sel;
      assign sel = slice_line_sel[cluster_ctrl_pkg::LINE_SEL_W*s +:
        cluster_ctrl_pkg::LINE_SEL_W];
      assign slice_tick[s] = (sel == cluster_ctrl_pkg::LINE_NONE)
        ? 1'b0 : line_tick[sel];
      assign slice_aclr[s] = async_clear[slice_clear_sel[s]];
      // aclr, then aload, then sync clear and load on edges
      assign q_next[s] = slice_aclr[s] ? cluster_ctrl_pkg::CLEAR_VALUE
        : async_load ? cluster_ctrl_pkg::PRESET_VALUE
        : !slice_tick[s] ? slice_q[s]
        : sync_clear ? cluster_ctrl_pkg::CLEAR_VALUE
        : sync_load ? slice_load_data[s]
        : slice_arith_mode[s] ? sum[s] : slice_data[s];

      // ********************************************************
      // checks per slice
      // ********************************************************
      property p_aclr;
        @(posedge clk) disable iff (!reset_n)
        slice_aclr[s] |=> slice_q[s] == cluster_ctrl_pkg::CLEAR_VALUE;
      endproperty
      a_aclr: assert property (p_aclr)
        else $error("async clear did not clear slice");

      property p_preset;
        @(posedge clk) disable iff (!reset_n)
        !slice_aclr[s] && async_load |=> slice_q[s] == 1'b1;
      endproperty
      a_preset: assert property (p_preset)
        else $error("async load did not preset slice");

      sequence s_quiet;
        !slice_tick[s] && !slice_aclr[s] && !async_load;
      endsequence
      property p_hold;
        @(posedge clk) disable iff (!reset_n)
        s_quiet ##1 s_quiet |=> $stable(slice_q[s]);
      endproperty
      a_hold: assert property (p_hold)
        else $error("slice changed without enabled edge");

      property p_sclr;
        @(posedge clk) disable iff (!reset_n)
        slice_tick[s] && sync_clear && !slice_aclr[s] && !async_load
        |=> slice_q[s] == 1'b0;
      endproperty
      a_sclr: assert property (p_sclr)
        else $error("sync clear ignored on edge");

      property p_sload;
        @(posedge clk) disable iff (!reset_n)
        slice_tick[s] && sync_load && !sync_clear && !slice_aclr[s]
        && !async_load |=> slice_q[s] == $past(slice_load_data[s]);
      endproperty
      a_sload: assert property (p_sload)
        else $error("sync load value wrong");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slice_q <= 8'h00;
    end else begin
      slice_q <= q_next;
    end
  end

  // ************************************************************
  // checks on lines and chain
  // ************************************************************
  generate
    for (l = 0; l < cluster_ctrl_pkg::LINE_COUNT; l++) begin : g_chk
      property p_gate;
        @(posedge clk) disable iff (!reset_n)
        !cluster_clock_gate[l] |=> !cluster_clock_tick[l];
      endproperty
      a_gate: assert property (p_gate)
        else $error("gated line still ticked");

      property p_pair;
        @(posedge clk) disable iff (!reset_n)
        cluster_clock_gate[l] && line_edge_sel[l] == 1'b0
        && rise_ev[line_source_sel[l]] |=> cluster_clock_tick[l];
      endproperty
      a_pair: assert property (p_pair)
        else $error("enabled rising edge missed on line");
    end
  endgenerate

  property p_two_edges;
    @(posedge clk) disable iff (!reset_n)
    line_source_sel[0] == line_source_sel[1] && line_edge_sel[0]
    != line_edge_sel[1] && (&cluster_clock_gate[1:0])
    |=> !(cluster_clock_tick[0] && cluster_clock_tick[1]);
  endproperty
  a_two_edges: assert property (p_two_edges)
    else $error("both edges on one cycle");

  property p_bypass;
    @(posedge clk) disable iff (!reset_n)
    half_bypass |-> (BOTTOM_BYPASS_COLUMN
      ? carry[cluster_ctrl_pkg::HALF_COUNT] == chain_in
      : chain_out == carry[cluster_ctrl_pkg::HALF_COUNT]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed half altered carry");

  property p_through;
    @(posedge clk) disable iff (!reset_n)
    !half_bypass && (&(operand_a ^ operand_b)) |-> chain_out == chain_in;
  endproperty
  a_through: assert property (p_through)
    else $error("carry did not propagate through cluster");

endmodule // logic_cluster
`default_nettype wire

// ==== bench/source_drive.sv ====
// far side model: user logic driving the two source clocks
`timescale 1ns/1ps
`default_nettype none
module source_drive (
  // clock
  input wire logic clk,
  // source clocks
  output logic [1:0] source_clock
);
  // ****************************************
  // source levels
  // ****************************************
  initial source_clock = 2'h0;
  // only two sources; a third line reuses one
  task automatic set_src(input int idx, input logic lvl, input int hold);
    @(negedge clk);
    source_clock[idx] <= lvl;
    repeat (hold) @(negedge clk);
  endtask
endmodule // source_drive
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the logic cluster control generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic clk, reset_n, async_load, sync_clear, sync_load;
  logic half_bypass, chain_in, chain_out, chain_out_bot;
  logic [1:0] source_clock, async_clear;
  logic [2:0] line_source_sel, line_edge_sel, cluster_clock_gate;
  logic [2:0] cluster_clock_tick;
  logic [15:0] slice_line_sel;
  logic [7:0] slice_clear_sel, slice_arith_mode, slice_data;
  logic [7:0] slice_load_data, operand_a, operand_b, slice_q;
  logic [7:0] tick_cnt [3];
  int n_errors, checked, cycles;
  source_drive u_src (.clk(clk), .source_clock(source_clock));
  logic_cluster u_dut (.clk(clk), .reset_n(reset_n),
    .source_clock(source_clock), .line_source_sel(line_source_sel),
    .line_edge_sel(line_edge_sel), .cluster_clock_gate(cluster_clock_gate),
    .async_clear(async_clear), .async_load(async_load),
    .sync_clear(sync_clear), .sync_load(sync_load),
    .slice_line_sel(slice_line_sel), .slice_clear_sel(slice_clear_sel),
    .slice_arith_mode(slice_arith_mode), .slice_data(slice_data),
    .slice_load_data(slice_load_data), .operand_a(operand_a),
    .operand_b(operand_b), .half_bypass(half_bypass),
    .chain_in(chain_in), .chain_out(chain_out), .slice_q(slice_q),
    .cluster_clock_tick(cluster_clock_tick));
  // neighbour column: bottom half bypassable
  logic_cluster #(.BOTTOM_BYPASS_COLUMN(1'b1)) u_dut_bottom (.clk(clk),
    .reset_n(reset_n), .source_clock(source_clock),
    .line_source_sel(line_source_sel), .line_edge_sel(line_edge_sel),
    .cluster_clock_gate(cluster_clock_gate), .async_clear(async_clear),
    .async_load(async_load), .sync_clear(sync_clear),
    .sync_load(sync_load), .slice_line_sel(slice_line_sel),
    .slice_clear_sel(slice_clear_sel), .slice_arith_mode(slice_arith_mode),
    .slice_data(slice_data), .slice_load_data(slice_load_data),
    .operand_a(operand_a), .operand_b(operand_b),
    .half_bypass(half_bypass), .chain_in(chain_in),
    .chain_out(chain_out_bot), .slice_q(), .cluster_clock_tick());
  // ****************************************
  // clock, tick counts and timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 3; i++) begin
      if (!reset_n) tick_cnt[i] = 8'h00;
      else if (cluster_clock_tick[i] === 1'b1) tick_cnt[i]++;
    end
    if (cycles >= 2000) begin
      n_errors++;
      close_out();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(input logic [7:0] t0, t1, t2);
    chk("tick line 0", t0, tick_cnt[0]);
    chk("tick line 1", t1, tick_cnt[1]);
    chk("tick line 2", t2, tick_cnt[2]);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    n_errors = 0; checked = 0; cycles = 0;
    reset_n = 1'b0; async_load = 1'b0; sync_clear = 1'b0; sync_load = 1'b0;
    half_bypass = 1'b0; chain_in = 1'b0; async_clear = 2'h0;
    line_source_sel = 3'h0; line_edge_sel = 3'h2; cluster_clock_gate = 3'h5;
    slice_line_sel = 16'hffe4; slice_clear_sel = 8'h00;
    slice_arith_mode = 8'h00; slice_data = 8'h07; slice_load_data = 8'h02;
    operand_a = 8'h0f; operand_b = 8'h01;
    step(2);
    reset_n = 1'b1;
    chk("slice_q reset", 8'h00, slice_q);
    u_src.set_src(0, 1'b1, 6);
    chk("slice_q rise", 8'h05, slice_q);
    ticks(8'h01, 8'h00, 8'h01);
    cluster_clock_gate = 3'h7;
    u_src.set_src(0, 1'b0, 6);
    chk("slice_q fall", 8'h07, slice_q);
    ticks(8'h01, 8'h01, 8'h01);
    sync_load = 1'b1;
    sync_clear = 1'b1;
    step(6);
    chk("sync without tick", 8'h07, slice_q);
    sync_clear = 1'b0;
    u_src.set_src(0, 1'b1, 6);
    chk("sync load", 8'h02, slice_q);
    sync_clear = 1'b1;
    u_src.set_src(0, 1'b0, 6);
    chk("sync clear over load", 8'h00, slice_q);
    ticks(8'h02, 8'h02, 8'h02);
    sync_clear = 1'b0;
    sync_load = 1'b0;
    async_load = 1'b1;
    step(2);
    chk("async load", 8'hff, slice_q);
    reset_n = 1'b0;
    step(2);
    chk("slice_q mid reset", 8'h00, slice_q);
    ticks(8'h00, 8'h00, 8'h00);
    reset_n = 1'b1;
    async_clear = 2'h1;
    step(2);
    chk("clear over load", 8'h00, slice_q);
    async_clear = 2'h0;
    step(2);
    slice_clear_sel = 8'hf0;
    async_load = 1'b0;
    async_clear = 2'h1;
    step(2);
    chk("clear select", 8'hf0, slice_q);
    async_clear = 2'h0;
    chk("chain no carry", 8'h00, {7'h00, chain_out});
    operand_a = 8'hff;
    step(1);
    chk("chain full", 8'h01, {7'h00, chain_out});
    operand_a = 8'h0f;
    half_bypass = 1'b1;
    step(1);
    chk("chain top bypass", 8'h01, {7'h00, chain_out});
    chk("chain bottom bypass", 8'h00, {7'h00, chain_out_bot});
    half_bypass = 1'b0;
    operand_a = 8'hff;
    operand_b = 8'h00;
    chain_in = 1'b1;
    step(1);
    chk("chain propagate", 8'h01, {7'h00, chain_out});
    operand_a = 8'h04;
    chain_in = 1'b0;
    line_source_sel = 3'h4;
    slice_arith_mode = 8'h04;
    u_src.set_src(1, 1'b1, 6);
    chk("slice_q sum", 8'hf4, slice_q);
    ticks(8'h00, 8'h00, 8'h01);
    async_clear = 2'h2;
    step(2);
    chk("second clear", 8'h04, slice_q);
    async_clear = 2'h0;
    close_out();
  end
endmodule // testbench
`default_nettype wire
